/* File: pkg/rph_regs.svh */
// Purpose: Constants for the serial repeater hub core
// Assumes: clk at 20 MHz
// Notes:   Times in us or ms, cycle counts derived from them
`ifndef RPH_REGS_SVH
`define RPH_REGS_SVH

`define RPH_CLK_HZ         20000000
`define RPH_N485           4
`define RPH_NPORT          5
`define RPH_P232           4
// Slowest supported rate, bits per second
`define RPH_BAUD_MIN       300
// Forwarding delay limit, us, and cycles allowed (rounded down)
`define RPH_FWD_MAX_US     5
`define RPH_FWD_MAX_CYC    ((`RPH_FWD_MAX_US * `RPH_CLK_HZ) / 1000000)
// Send-to-receive turnaround, us typical and max
`define RPH_TURN_TYP_US    10
`define RPH_TURN_MAX_US    100
`define RPH_TURN_CYC       ((`RPH_TURN_TYP_US * `RPH_CLK_HZ) / 1000000)
// Line idle time ending a frame: 11 bit times at slowest rate
`define RPH_IDLE_CYC       ((11 * `RPH_CLK_HZ) / `RPH_BAUD_MIN)
// Indicator stretch, ms
`define RPH_LED_MS         20
`define RPH_LED_CYC        ((`RPH_LED_MS * `RPH_CLK_HZ) / 1000)
// Fault: echo mismatch count before a channel is cut off
`define RPH_FAULT_CNT      8'h10
// Cycles after driver turns on before fault checking starts
`define RPH_ECHO_SKIP      4'h4

`endif

/* File: pkg/rph_pkg.sv */
// Purpose: Types for the serial repeater hub core
// Assumes: Constants come from rph_regs.svh
// Notes:   Port index 0..3 are RS485 channels, 4 is RS232
package rph_pkg;
  typedef enum logic [1:0] {
    RPH_IDLE,
    RPH_FWD,
    RPH_TURN
  } rph_state_t;
  typedef logic [2:0] rph_port_t;
endpackage

/* File: design/rph_sync.sv */
// Purpose: Two-flop synchroniser with activity stretch for one port
// Assumes: Input is asynchronous to clk
// Notes:   Stage one feeds stage two only
`timescale 1ns/1ps
`include "rph_regs.svh"
module rph_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,     // System clock
  input  wire logic rst,     // Sync reset, active high
  input  wire logic d_in,    // Raw pin level
  input  wire logic edge_en, // Count edges toward indicator
  output logic      q_out,   // Synchronised level
  output logic      led      // Receive indicator
);
  logic        s1_r;
  logic        s2_r;
  logic        s3_r;
  logic [21:0] led_cnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Stretch each received edge while edge_en is high so the indicator flashes visibly
  always_ff @(posedge clk) begin
    if (rst) begin
      led_cnt_r <= 22'h0;
    end else if (edge_en && (s2_r != s3_r)) begin
      led_cnt_r <= 22'(`RPH_LED_CYC);
    end else if (led_cnt_r != 22'h0) begin
      led_cnt_r <= led_cnt_r - 22'h1;
    end
  end

  assign q_out = s2_r;
  assign led   = (led_cnt_r != 22'h0);
endmodule

/* File: design/rph_hub.sv */
// Purpose: Forwarding core of a five-port serial repeater hub
// Assumes: RS485 rx/tx are logic levels (1 = idle/mark, A>B); RS232 pins
//          are logic-level too, idle low as at the connector
// Notes:   Bit stream is copied sample by sample, so baud is transparent
`timescale 1ns/1ps
`include "rph_regs.svh"
module rph_hub (
  input  wire logic       clk,          // System clock, 20 MHz
  input  wire logic       rst,          // Sync reset, active high
  input  wire logic [3:0] rs485_rx,     // RS485 receiver outputs
  output logic      [3:0] rs485_tx,     // RS485 driver data
  output logic      [3:0] rs485_de,     // RS485 driver enables
  input  wire logic       rs232_rx,     // RS232 receive pin, idle low
  output logic            rs232_tx,     // RS232 transmit pin, idle low
  output logic            led_power,    // Power indicator
  output logic            led_rs232,    // RS232 receive indicator
  output logic      [3:0] led_rs485,    // RS485 receive indicators
  output logic      [3:0] chan_cut      // RS485 channel cut off
);
  logic [4:0]         raw_in;
  logic [4:0]         line;           // 1 = mark for every port
  logic [4:0]         led_v;
  logic [4:0]         edge_en;
  rph_pkg::rph_state_t state_r;
  rph_pkg::rph_port_t  src_r;
  logic [4:0]         start_v;
  logic               src_bit;
  logic [19:0]        idle_cnt_r;
  logic [7:0]         turn_cnt_r;
  logic               fwd_bit_r;
  logic               tx_d1_r;        // Driven bit, one cycle old
  logic               tx_d2_r;        // Driven bit, two cycles old
  logic [3:0]         de_r;
  logic               tx232_r;
  logic [3:0]         cut_r;
  logic [7:0]         fault_cnt_r [4];
  logic [3:0]         echo_age_r [4];
  logic               pwr_r;

  // inverted RS232 pin so all ports share mark = 1
  assign raw_in = {~rs232_rx, rs485_rx};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      rph_sync #(
        .RST_VAL (1'b1)
      ) u_sync (
        .clk     (clk),
        .rst     (rst),
        .d_in    (raw_in[g]),
        .edge_en (edge_en[g]),
        .q_out   (line[g]),
        .led     (led_v[g])
      );
    end
  endgenerate

  // only the active source flashes its indicator
  always_comb begin
    edge_en = 5'h0;
    if (state_r == rph_pkg::RPH_FWD) begin
      edge_en[src_r] = 1'b1;
    end
  end

  // start bit on a listening, uncut port
  always_comb begin
    start_v = ~line;
    start_v[3:0] = start_v[3:0] & ~cut_r;
  end

  assign src_bit = line[src_r];

  // arbiter picks any one of five ports as the input
  // with two inputs the lowest index wins; data is corrupt anyway
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= rph_pkg::RPH_IDLE;
      src_r   <= 3'h0;
    end else begin
      case (state_r)
        rph_pkg::RPH_IDLE: begin
          if (start_v != 5'h0) begin
            state_r <= rph_pkg::RPH_FWD;
            if (start_v[0]) begin
              src_r <= 3'h0;
            end else if (start_v[1]) begin
              src_r <= 3'h1;
            end else if (start_v[2]) begin
              src_r <= 3'h2;
            end else if (start_v[3]) begin
              src_r <= 3'h3;
            end else begin
              src_r <= 3'(`RPH_P232);
            end
          end
        end
        rph_pkg::RPH_FWD: begin
          // Source cut by fault ends the frame at once
          if (idle_cnt_r == 20'(`RPH_IDLE_CYC) ||
              (src_r != 3'(`RPH_P232) && cut_r[src_r[1:0]])) begin
            state_r <= rph_pkg::RPH_TURN;
          end
        end
        rph_pkg::RPH_TURN: begin
          if (turn_cnt_r == 8'(`RPH_TURN_CYC)) begin
            state_r <= rph_pkg::RPH_IDLE;
          end
        end
        default: state_r <= rph_pkg::RPH_IDLE;
      endcase
    end
  end

  // idle length at slowest rate marks frame end at any baud
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_cnt_r <= 20'h0;
    end else if (state_r != rph_pkg::RPH_FWD || !src_bit) begin
      idle_cnt_r <= 20'h0;
    end else if (idle_cnt_r != 20'(`RPH_IDLE_CYC)) begin
      idle_cnt_r <= idle_cnt_r + 20'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      turn_cnt_r <= 8'h0;
    end else if (state_r == rph_pkg::RPH_TURN) begin
      turn_cnt_r <= turn_cnt_r + 8'h1;
    end else begin
      turn_cnt_r <= 8'h0;
    end
  end

  // copy source level each cycle; one register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      fwd_bit_r <= 1'b1;
    end else if (state_r == rph_pkg::RPH_FWD) begin
      fwd_bit_r <= src_bit;
    end else begin
      fwd_bit_r <= 1'b1;
    end
  end

  // echo returns through two sync stages, so delay the reference
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_d1_r <= 1'b1;
      tx_d2_r <= 1'b1;
    end else begin
      tx_d1_r <= fwd_bit_r;
      tx_d2_r <= tx_d1_r;
    end
  end

  // drivers drop after turnaround; off when idle
  always_ff @(posedge clk) begin
    if (rst) begin
      de_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (state_r == rph_pkg::RPH_IDLE || cut_r[i]) begin
          de_r[i] <= 1'b0;
        end else if (state_r == rph_pkg::RPH_FWD) begin
          de_r[i] <= (src_r != 3'(i));
        end
      end
    end
  end

  // RS232 output is inverse of RS485 state, held low while RS232 is the source
  always_ff @(posedge clk) begin
    if (rst) begin
      tx232_r <= 1'b0;
    end else if (state_r == rph_pkg::RPH_FWD &&
                 src_r != 3'(`RPH_P232)) begin
      tx232_r <= ~src_bit;
    end else begin
      tx232_r <= 1'b0;
    end
  end

  // echo of own driven level disagrees -> short or reversal
  always_ff @(posedge clk) begin
    if (rst) begin
      cut_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        fault_cnt_r[i] <= 8'h0;
        echo_age_r[i]  <= 4'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!de_r[i]) begin
          echo_age_r[i] <= 4'h0;
        end else if (echo_age_r[i] != `RPH_ECHO_SKIP) begin
          echo_age_r[i] <= echo_age_r[i] + 4'h1;
        end
        if (de_r[i] && echo_age_r[i] == `RPH_ECHO_SKIP &&
            line[i] != tx_d2_r) begin
          if (fault_cnt_r[i] == `RPH_FAULT_CNT) begin
            cut_r[i] <= 1'b1;
          end else begin
            fault_cnt_r[i] <= fault_cnt_r[i] + 8'h1;
          end
        end
      end
    end
  end

  // power indicator lit once out of reset
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_r <= 1'b0;
    end else begin
      pwr_r <= 1'b1;
    end
  end

  assign rs485_tx  = {4{fwd_bit_r}};
  assign rs485_de  = de_r;
  assign rs232_tx  = tx232_r;
  assign led_power = pwr_r;
  assign led_rs232 = led_v[4];
  assign led_rs485 = led_v[3:0];
  assign chan_cut  = cut_r;
endmodule

/* File: tb/rph_hub_assertions.sv */
// Purpose: Port checks for the repeater hub core
// Assumes: One clk domain, rst synchronous active high
// Notes:   Bound to rph_hub below
`timescale 1ns/1ps
module rph_hub_assertions (
  input wire logic       clk,       // Clock
  input wire logic       rst,       // Reset
  input wire logic [3:0] rs485_rx,  // RS485 receive
  input wire logic [3:0] rs485_tx,  // RS485 data out
  input wire logic [3:0] rs485_de,  // RS485 enables
  input wire logic       rs232_rx,  // RS232 receive
  input wire logic       rs232_tx,  // RS232 out
  input wire logic       led_power, // Power indicator
  input wire logic       led_rs232, // RS232 indicator
  input wire logic [3:0] led_rs485, // RS485 indicators
  input wire logic [3:0] chan_cut   // Cut-off flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence idle_start_s;
    rs485_de == 4'h0 && (~rs485_rx & ~chan_cut) != 4'h0;
  endsequence
  sequence drive_on_s;
    ##[1:100] rs485_de != 4'h0;
  endsequence
  reset_state_a: assert property (disable iff (1'b0)
    rst |=> rs485_de == 4'h0 && chan_cut == 4'h0 && led_rs485 == 4'h0)
    else $error("outputs not at reset state");
  power_led_a: assert property (!$past(rst) |-> led_power)
    else $error("power indicator dark");
  fwd_latency_a: assert property (idle_start_s |-> drive_on_s)
    else $error("forwarding did not start in time");
  tx_equal_a: assert property (
    (rs485_de | chan_cut) == 4'hd |->
      rs485_tx == {4{$past(rs485_rx[1], 3)}})
    else $error("drivers do not copy the channel 1 stream");
  rs232_inv_a: assert property (
    rs485_de != 4'h0 && rs485_de != 4'hf |-> rs232_tx == !rs485_tx[0])
    else $error("RS232 level not inverse");
  cut_quiet_a: assert property (
    chan_cut != 4'h0 |=> (rs485_de & $past(chan_cut)) == 4'h0)
    else $error("cut channel still drives");
  cut_sticky_a: assert property (
    (chan_cut & $past(chan_cut)) == $past(chan_cut))
    else $error("cut flag cleared without reset");
  led_source_a: assert property (
    ((led_rs485 & ~$past(led_rs485)) & rs485_de) == 4'h0)
    else $error("indicator lit on a driving port");
endmodule
bind rph_hub rph_hub_assertions rph_hub_assertions_inst (.clk(clk),
  .rst(rst), .rs485_rx(rs485_rx), .rs485_tx(rs485_tx),
  .rs485_de(rs485_de), .rs232_rx(rs232_rx), .rs232_tx(rs232_tx),
  .led_power(led_power), .led_rs232(led_rs232),
  .led_rs485(led_rs485), .chan_cut(chan_cut));

/* File: tb/rph_node_model.sv */
// Purpose: Far-side RS485 nodes, one per channel
// Assumes: Hub drives the pair whenever its enable is high
// Notes:   Fault bit models a reversed pair on that channel
`timescale 1ns/1ps
module rph_node_model (
  input  wire logic [3:0] tx,    // Hub driver data
  input  wire logic [3:0] de,    // Hub driver enables
  input  wire logic [3:0] drv,   // Node level while hub listens
  input  wire logic [3:0] fault, // Reversed wiring per channel
  output logic      [3:0] rx     // Level seen by hub receivers
);
  assign rx = (de & (tx ^ fault)) | (~de & drv);
endmodule

/* File: tb/multiport_serial_repeater_hub_tb_top.sv */
// Purpose: Self-checking bench for the repeater hub core
// Assumes: One frame per reset; idle timeout is far beyond run length
// Notes:   Channel 1 is the source, then RS232 after a second reset
`timescale 1ns/1ps
module multiport_serial_repeater_hub_tb_top;
  logic       clk, rst, rs232_rx, rs232_tx, led_power, led_rs232;
  logic [3:0] drv, fault, rs485_rx, rs485_tx, rs485_de;
  logic [3:0] led_rs485, chan_cut;
  int         bad_count, compares, n;
  logic [5:0] rows [8] = '{6'h01, 6'h3e, 6'h01, 6'h01, 6'h3e, 6'h01,
                           6'h3e, 6'h3e};
  rph_hub rph_hub_inst (.clk(clk), .rst(rst), .rs485_rx(rs485_rx),
    .rs485_tx(rs485_tx), .rs485_de(rs485_de), .rs232_rx(rs232_rx),
    .rs232_tx(rs232_tx), .led_power(led_power), .led_rs232(led_rs232),
    .led_rs485(led_rs485), .chan_cut(chan_cut));
  rph_node_model rph_node_model_inst (.tx(rs485_tx), .de(rs485_de),
    .drv(drv), .fault(fault), .rx(rs485_rx));
  always #25 clk = ~clk;
  task chk(string name, logic [3:0] exp, logic [3:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cyc(int k);
    repeat (k) @(posedge clk);
  endtask
  initial begin
    clk = 0; rst = 1; drv = 4'hf; fault = 4'h0; rs232_rx = 0;
    begin : scen
      cyc(2);
      chk("de", 4'h0, rs485_de);
      chk("rs232_tx", 4'h0, {3'h0, rs232_tx});
      cyc(1);
      rst <= 0;
      cyc(3);
      chk("led_power", 4'h1, {3'h0, led_power});
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
        drv <= {2'b11, rows[i][5], 1'b1};
        cyc(8);
        chk("tx", rows[i][4:1], rs485_tx);
        chk("rs232_tx", {3'h0, rows[i][0]}, {3'h0, rs232_tx});
        chk("de", 4'hd, rs485_de);
      end
      chk("led_rs485", 4'h2, led_rs485);
      chk("led_rs232", 4'h0, {3'h0, led_rs232});
      $display("test forwarding done");
      rs232_rx <= 1;
      drv <= 4'hd;
      cyc(8);
      chk("tx", 4'h0, rs485_tx);
      drv <= 4'hf;
      cyc(8);
      chk("tx", 4'hf, rs485_tx);
      chk("led_rs232", 4'h0, {3'h0, led_rs232});
      rs232_rx <= 0;
      $display("test second input done");
      fault <= 4'h8;
      for (n = 0; n < 200 && chan_cut[3] !== 1'b1; n++) cyc(1);
      if (n == 200) begin
        bad_count++;
        $display("FAIL chan_cut expected 8 seen %h", chan_cut);
        disable scen;
      end
      cyc(2);
      chk("chan_cut", 4'h8, chan_cut);
      chk("de", 4'h5, rs485_de);
      drv <= 4'hd;
      cyc(8);
      chk("tx", 4'h0, rs485_tx & 4'h7);
      chk("rs232_tx", 4'h1, {3'h0, rs232_tx});
      $display("test channel fault done");
      // Second reset mid-run, lines idle, then RS232 becomes the source
      rst <= 1;
      drv <= 4'hf;
      fault <= 4'h0;
      cyc(3);
      rst <= 0;
      chk("de", 4'h0, rs485_de);
      chk("chan_cut", 4'h0, chan_cut);
      chk("led_rs485", 4'h0, led_rs485);
      cyc(2);
      rs232_rx <= 1;
      cyc(8);
      chk("de", 4'hf, rs485_de);
      chk("tx", 4'h0, rs485_tx);
      chk("rs232_tx", 4'h0, {3'h0, rs232_tx});
      rs232_rx <= 0;
      cyc(8);
      chk("tx", 4'hf, rs485_tx);
      chk("led_rs232", 4'h1, {3'h0, led_rs232});
      chk("led_rs485", 4'h0, led_rs485);
      $display("test RS232 source done");
    end
    final_report();
  end
endmodule
